// ==== logic/dbes_defs.svh ====
`ifndef DBES_DEFS_SVH
`define DBES_DEFS_SVH
`define DBES_OFS_STATUS 8'h14
`define DBES_OFS_MASK   8'h10
`define DBES_OFS_ENABLE 8'h0c
`define DBES_RST_STATUS 32'h0000_0000
`define DBES_RST_MASK   32'h0000_0000
`define DBES_RST_ENABLE 32'h0000_0000
`define DBES_ADDR_W     8
`endif

// ==== logic/dbes_pkg.sv ====
package dbes_pkg;
  typedef enum logic [1:0] {
    DBES_IDLE = 2'b00,
    DBES_RESP = 2'b01
  } dbes_bus_st_t;
endpackage : dbes_pkg

// ==== logic/dbes_chan_err.sv ====
`timescale 1ns/1ns
// Per-channel sticky error flag and enable bit
module dbes_chan_err (
  input  wire logic clk_sys,
  input  wire logic rst_sync_n,
  input  wire logic err_resp,
  input  wire logic err_clr,
  input  wire logic en_set,
  input  wire logic en_clr,
  output logic      flag_reg,
  output logic      enable_reg
);
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flag_reg <= 1'b0;
    end else if (err_resp) begin
      flag_reg <= 1'b1;                             // set beats clear
    end else if (err_clr) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      enable_reg <= 1'b0;
    end else if (err_resp) begin
      enable_reg <= 1'b0;
    end else if (en_set) begin
      enable_reg <= 1'b1;
    end else if (en_clr) begin
      enable_reg <= 1'b0;
    end
  end
endmodule : dbes_chan_err

// ==== logic/dbes_top.sv ====
`timescale 1ns/1ns
`include "dbes_defs.svh"
module dbes_top
  import dbes_pkg::*;
#(
  parameter int NCH = 32
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic [`DBES_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   ahb_resp_valid,
  input  wire logic                   ahb_hresp_err,
  input  wire logic [4:0]             ahb_resp_chan,
  output logic      [NCH-1:0]         chan_enable,
  output logic                        irq
);
  logic              rst_meta_reg;
  logic              rst_sync_n;
  dbes_bus_st_t      bus_st_reg;
  logic [NCH-1:0]    flag;
  logic [NCH-1:0]    enable;
  logic [NCH-1:0]    mask_reg;
  logic [NCH-1:0]    err_hit;
  logic [31:0]       be_mask;
  logic [31:0]       wr_ones;
  logic [31:0]       wr_zeros;
  logic              wr_take;
  logic              wr_status;
  logic              wr_mask;
  logic              wr_enable;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  assign be_mask = lane_mask(avs_byteenable);
  // One wait cycle per access; taken when the slave drops waitrequest
  assign wr_take   = avs_write && (bus_st_reg == DBES_RESP);
  assign wr_status = wr_take && (avs_address == `DBES_OFS_STATUS);
  assign wr_mask   = wr_take && (avs_address == `DBES_OFS_MASK);
  assign wr_enable = wr_take && (avs_address == `DBES_OFS_ENABLE);
  // Lanes left out by byteenable neither clear nor set anything
  assign wr_ones   = avs_writedata & be_mask;
  assign wr_zeros  = ~avs_writedata & be_mask;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_st_reg <= DBES_IDLE;
    end else begin
      unique case (bus_st_reg)
        DBES_IDLE: begin
          if (avs_read || avs_write) begin
            bus_st_reg <= DBES_RESP;
          end
        end
        DBES_RESP: begin
          bus_st_reg <= DBES_IDLE;
        end
        default: begin
          bus_st_reg <= DBES_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && (bus_st_reg == DBES_IDLE));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && (bus_st_reg == DBES_IDLE)) begin
      // Unmapped addresses read zero
      unique case (avs_address)
        `DBES_OFS_STATUS: avs_readdata <= flag;
        `DBES_OFS_MASK:   avs_readdata <= mask_reg;
        `DBES_OFS_ENABLE: avs_readdata <= enable;
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask_reg <= `DBES_RST_MASK;
    end else if (wr_mask) begin
      mask_reg <= (mask_reg & ~be_mask) | wr_ones;
    end
  end

  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    assign err_hit[ch] = ahb_resp_valid && ahb_hresp_err
                         && (ahb_resp_chan == 5'(ch));
    dbes_chan_err u_chan (
      .clk_sys    (clk_sys),
      .rst_sync_n (rst_sync_n),
      .err_resp   (err_hit[ch]),
      .err_clr    (wr_status && wr_ones[ch]),
      .en_set     (wr_enable && wr_ones[ch]),
      .en_clr     (wr_enable && wr_zeros[ch]),
      .flag_reg   (flag[ch]),
      .enable_reg (enable[ch])
    );
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chan_enable <= `DBES_RST_ENABLE;
      irq         <= 1'b0;
    end else begin
      // Registered: irq lags the flag by one cycle; err_hit drops chan_enable on the same edge that sets the flag
      chan_enable <= enable & ~err_hit;
      irq         <= |(flag & mask_reg);
    end
  end

endmodule : dbes_top

// ==== bench/dbes_ahb_slv.sv ====
`timescale 1ns/1ns
module dbes_ahb_slv (
  input  wire logic        clk_sys,
  input  wire logic [31:0] chan_enable,
  input  wire logic        go,
  input  wire logic        err,
  input  wire logic [4:0]  chan,
  output logic             ahb_resp_valid = 1'b0,
  output logic             ahb_hresp_err  = 1'b0,
  output logic [4:0]       ahb_resp_chan  = 5'h0
);
  always_ff @(posedge clk_sys) begin
    ahb_resp_valid <= go && chan_enable[chan];
    // Toggle outside a response so stale values never look valid
    ahb_hresp_err <= go ? err : ~ahb_hresp_err;
    ahb_resp_chan <= go ? chan : ~ahb_resp_chan;
  end
endmodule : dbes_ahb_slv

// ==== bench/dbes_assertions.sv ====
`timescale 1ns/1ns
module dbes_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        ahb_resp_valid,
  input wire logic        ahb_hresp_err,
  input wire logic [4:0]  ahb_resp_chan,
  input wire logic [31:0] chan_enable,
  input wire logic        irq
);
  logic wr_go;
  assign wr_go = avs_write && !avs_waitrequest;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("no answer after one wait");
  err_off_a: assert property (ahb_resp_valid && ahb_hresp_err |=>
    !chan_enable[$past(ahb_resp_chan)]) else $error("channel kept after error");
  en_up_a: assert property ((chan_enable & ~$past(chan_enable)) != 32'h0 |->
    $past(wr_go && avs_address == 8'h0c, 2)) else $error("enable rose alone");
  irq_up_a: assert property ($rose(irq) |-> $past(ahb_resp_valid && ahb_hresp_err, 2) ||
    $past(wr_go && avs_address == 8'h10, 2)) else $error("irq rose alone");
  irq_down_a: assert property ($fell(irq) |->
    $past(wr_go && avs_address[7:3] == 5'h02, 2)) else $error("irq fell alone");
  rd_hole_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h04 |->
    avs_readdata == 32'h0) else $error("unmapped read not zero");
endmodule : dbes_chk
bind dbes_top dbes_chk u_chk (.*);

// ==== bench/dbes_tb_top.sv ====
`timescale 1ns/1ns
module dbes_tb_top;
  logic        clk_sys = 0, rst_n = 0, avs_read = 0, avs_write = 0, go = 0, err = 0;
  logic [7:0]  avs_address = 8'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, chan_enable, q;
  logic        avs_waitrequest, irq, ahb_resp_valid, ahb_hresp_err;
  logic [4:0]  chan = 5'h0, ahb_resp_chan;
  int          n_errors = 0, checks_done = 0;
  initial forever #25 clk_sys = ~clk_sys;
  dbes_top dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .ahb_resp_valid,
    .ahb_hresp_err, .ahb_resp_chan, .chan_enable, .irq);
  dbes_ahb_slv u_slv (.clk_sys, .chan_enable, .go, .err, .chan, .ahb_resp_valid,
    .ahb_hresp_err, .ahb_resp_chan);
  task end_of_test;
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    {avs_read, avs_write, avs_address, avs_writedata} <= {!w, w, a, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      n_errors++;
      end_of_test();
    end
    q = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
  endtask : acc
  task rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    cmp(q, e);
  endtask : rd
  task resp(input int c, input logic e);
    @(posedge clk_sys);
    {go, err, chan} <= {1'b1, e, c[4:0]};
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : resp
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(8'h14, 32'h0);
    rd(8'h10, 32'h0);
    acc(1'b1, 8'h0c, 32'hffffffff);
    acc(1'b1, 8'h04, 32'h00001234);
    rd(8'h04, 32'h0);
    for (int i = 0; i < 32; i++) resp(i, i[0]);
    rd(8'h14, 32'haaaaaaaa);
    cmp(chan_enable, 32'h55555555);
    rd(8'h0c, 32'h55555555);
    cmp({31'h0, irq}, 32'h0);
    acc(1'b1, 8'h10, 32'h80000000);
    rd(8'h10, 32'h80000000);
    repeat (2) @(negedge clk_sys);
    cmp({31'h0, irq}, 32'h1);
    acc(1'b1, 8'h14, 32'h7fffffff);
    rd(8'h14, 32'h80000000);
    acc(1'b1, 8'h14, 32'hffffffff);
    rd(8'h14, 32'h0);
    @(negedge clk_sys);
    cmp({31'h0, irq}, 32'h0);
    end_of_test();
  end
endmodule : dbes_tb_top
